// >>> dtc_pkg.sv
package dtc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL = 6'h20;
    localparam logic [5:0] IDX_STATUS = 6'h21;
    localparam logic [5:0] IDX_SEQ = 6'h27;
    localparam logic [5:0] IDX_COUNT = 6'h2A;
    localparam logic [5:0] IDX_TDATA = 6'h2B;
    localparam logic [7:0] ADDR_CTRL = {IDX_CTRL, 2'b00};
    localparam logic [7:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
    localparam logic [7:0] ADDR_SEQ = {IDX_SEQ, 2'b00};
    localparam logic [7:0] ADDR_COUNT = {IDX_COUNT, 2'b00};
    localparam logic [7:0] ADDR_TDATA = {IDX_TDATA, 2'b00};

    // Bus widths
    localparam int AW = 8;
    localparam int DW = 32;

    // Field positions in debug_control_first
    localparam int CTRL_ARM_BIT = 7;
    localparam int CTRL_END_BIT = 6;
    localparam int CTRL_VIEW_LSB = 0;

    // Field positions in trace_line_counter and debug_status_register
    localparam int FULL_BIT = 7;
    localparam int STATUS_ARM_BIT = 0;

    // Trace geometry
    localparam int LINE_W = 20;
    localparam int CNT_W = 6;
    localparam int DEPTH = 64;

    // Reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SEQ_RST = 8'h00;
    localparam logic [5:0] CNT_RST = 6'h00;

    // View select encodings
    typedef enum logic [1:0] {
        DTC_VIEW_S1 = 2'b00,
        DTC_VIEW_S2 = 2'b01,
        DTC_VIEW_S3 = 2'b10,
        DTC_VIEW_MATCH = 2'b11
    } dtc_view_t;

endpackage

// >>> dtc_trace_counter.sv
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
// Overview of operation
// - Full flag sets once 64 or more lines captured since last arming.
// - While full flag set, all 64 lines count as valid.
// - Writing one to arm bit clears full flag and line count.
// - Of the two resets, only power-on reset clears flag and count; system reset keeps them.
// - Six-bit count in bits 5..0 reports valid 20-bit lines stored.
// - Count wrap sets full flag; end-trigger mode keeps counting.
// - Reading trace entries never decrements the count.
// - Flag clear: count equals valid lines, 0 none through 63.
// - Wrap with begin alignment clears arm and ends the session.
// - Flag set with nonzero count: 64 valid, oldest overwritten.
// - Full flag at bit 7 of counter and mirrored in status bit 7.
// - States 1 to 3 each own a sequencer control register.
// - All three share one address, chosen by the view-select field.
// - View select 11 shows the match flag register there.
module dtc_trace_counter #(
    parameter int LINES = dtc_pkg::DEPTH
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sys_rst_b,
    input wire logic [dtc_pkg::AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [dtc_pkg::DW-1:0] avs_writedata,
    output logic [dtc_pkg::DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic trace_valid,
    input wire logic [dtc_pkg::LINE_W-1:0] trace_data,
    input wire logic [7:0] match_flags,
    output logic [23:0] seq_state_ctrl,
    output logic session_armed,
    output logic [6:0] valid_lines
);
    import dtc_pkg::*;

    // Elaboration guard: count field and full flag serve exactly 64 lines
    if (LINES != DEPTH) begin : g_lines_check
        $error("dtc_trace_counter: LINES must equal the 64-line buffer");
    end

    logic ack_r;
    logic [DW-1:0] rdata_r;
    logic [7:0] ctrl_r;
    logic [7:0] seq_r [3];
    logic [CNT_W-1:0] cnt_r;
    logic full_r;
    logic [CNT_W-1:0] rptr_r;
    logic [LINE_W-1:0] buf_r [DEPTH];
    logic [LINE_W-1:0] tline_r;

    // Bus handshake: one wait cycle, then the access is taken
    wire req = avs_read | avs_write;
    wire take = req & ack_r;
    wire wr_take = avs_write & ack_r;
    wire rd_take = avs_read & ack_r;
    assign avs_waitrequest = req & ~ack_r;

    // Address decode
    wire hit_ctrl = avs_address == ADDR_CTRL;
    wire hit_status = avs_address == ADDR_STATUS;
    wire hit_seq = avs_address == ADDR_SEQ;
    wire hit_count = avs_address == ADDR_COUNT;
    wire hit_tdata = avs_address == ADDR_TDATA;

    // Control fields
    wire arm = ctrl_r[CTRL_ARM_BIT];
    wire end_mode = ctrl_r[CTRL_END_BIT];
    wire [1:0] view = ctrl_r[CTRL_VIEW_LSB +: 2];
    wire arm_wr = wr_take & hit_ctrl & avs_writedata[CTRL_ARM_BIT];
    wire capture = arm & trace_valid & ~arm_wr;
    wire wrap = capture & (cnt_r == {CNT_W{1'b1}});
    wire stop = wrap & ~end_mode;

    // Shared address: state control view or match flags
    wire seq_view = hit_seq & (view != DTC_VIEW_MATCH);
    wire [7:0] seq_rd = (view == DTC_VIEW_MATCH) ? match_flags : seq_r[view];
    wire [7:0] count_rd = {full_r, 1'b0, cnt_r};
    wire [7:0] status_rd = {full_r, 6'h00, arm};

    // Read mux; unmapped addresses read zero
    wire [7:0] rd_byte = hit_ctrl ? ctrl_r :
                         hit_status ? status_rd :
                         hit_seq ? seq_rd :
                         hit_count ? count_rd : 8'h00;
    wire [DW-1:0] rd_word = hit_tdata ? {12'h000, tline_r} : {24'h000000, rd_byte};

    // Valid line report
    assign valid_lines = full_r ? 7'h40 : {1'b0, cnt_r};
    assign session_armed = arm;
    assign avs_readdata = rdata_r;

    // Bus acknowledge and read data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= req & ~ack_r;
            if (avs_read & ~ack_r) begin
                rdata_r <= rd_word;
            end
        end
    end

    // Control register; system reset clears it, hardware may end the session
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RST;
        end else if (!sys_rst_b) begin
            ctrl_r <= CTRL_RST;
        end else if (wr_take & hit_ctrl) begin
            ctrl_r <= avs_writedata[7:0];
        end else if (stop) begin
            ctrl_r[CTRL_ARM_BIT] <= 1'b0;
        end
    end

    // Per-state sequencer control registers behind the shared address
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_seq
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    seq_r[gi] <= SEQ_RST;
                end else if (!sys_rst_b) begin
                    seq_r[gi] <= SEQ_RST;
                end else if (wr_take & seq_view & (view == 2'(gi))) begin
                    seq_r[gi] <= avs_writedata[7:0];
                end
            end
            assign seq_state_ctrl[gi*8 +: 8] = seq_r[gi];
        end
    endgenerate

    // Line count and full flag: power-on reset only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= CNT_RST;
            full_r <= 1'b0;
        end else if (arm_wr) begin
            cnt_r <= CNT_RST;
            full_r <= 1'b0;
        end else if (capture) begin
            cnt_r <= cnt_r + 6'h01;
            if (wrap) begin
                full_r <= 1'b1;
            end
        end
    end

    // Trace buffer write at the count position
    always_ff @(posedge clk) begin
        if (capture) begin
            buf_r[cnt_r] <= trace_data;
        end
    end

    // Trace readout; pointer steps without touching the count
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rptr_r <= CNT_RST;
            tline_r <= '0;
        end else begin
            tline_r <= buf_r[rptr_r];
            if (arm_wr) begin
                rptr_r <= CNT_RST;
            end else if (rd_take & hit_tdata) begin
                rptr_r <= rptr_r + 6'h01;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_arm_clears;
        arm_wr |=> (cnt_r == 6'h00) && !full_r;
    endproperty
    a_arm_clears: assert property (p_arm_clears) else $error("arm write did not clear");

    property p_count_step;
        capture |=> cnt_r == 6'($past(cnt_r) + 6'h01);
    endproperty
    a_count_step: assert property (p_count_step) else $error("count step wrong");

    property p_wrap_full;
        wrap |=> full_r ##0 (cnt_r == 6'h00);
    endproperty
    a_wrap_full: assert property (p_wrap_full) else $error("wrap did not set full");

    property p_begin_stop;
        (wrap && !end_mode && !(wr_take && hit_ctrl)) |=> !arm;
    endproperty
    a_begin_stop: assert property (p_begin_stop) else $error("begin session not ended");

    property p_end_keep;
        (wrap && end_mode && sys_rst_b && !(wr_take && hit_ctrl)) |=> arm ##1 1'b1;
    endproperty
    a_end_keep: assert property (p_end_keep) else $error("end mode stopped");

    property p_sysrst_hold;
        (!sys_rst_b && !trace_valid && !arm_wr) |=> $stable(cnt_r) && $stable(full_r);
    endproperty
    a_sysrst_hold: assert property (p_sysrst_hold) else $error("system reset hit count");

    property p_read_nodec;
        (rd_take && hit_tdata && !capture && !arm_wr) |=> $stable(cnt_r);
    endproperty
    a_read_nodec: assert property (p_read_nodec) else $error("read changed count");

    property p_full_all;
        full_r |-> valid_lines == 7'h40;
    endproperty
    a_full_all: assert property (p_full_all) else $error("full not 64 lines");

    property p_status_mirror;
        (avs_read && !ack_r && hit_status) |=> avs_readdata[7] == $past(full_r);
    endproperty
    a_status_mirror: assert property (p_status_mirror) else $error("status bit 7 wrong");

    property p_match_view;
        (avs_read && !ack_r && hit_seq && view == 2'b11) |=>
            avs_readdata[7:0] == $past(match_flags);
    endproperty
    a_match_view: assert property (p_match_view) else $error("match view wrong");

    // Count and flag sequencing across captures, arming and resets
    property p_count_idle;
        (!capture && !arm_wr) |=> $stable(cnt_r);
    endproperty
    a_count_idle: assert property (p_count_idle) else $error("count moved idle");

    property p_no_cap_disarmed;
        (!arm && !arm_wr) |=> $stable(cnt_r) && $stable(full_r);
    endproperty
    a_no_cap_disarmed: assert property (p_no_cap_disarmed) else $error("disarmed capture");

    property p_full_hold;
        (full_r && !arm_wr) |=> full_r;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full flag dropped");

    property p_full_only_wrap;
        (!full_r && !wrap) |=> !full_r;
    endproperty
    a_full_only_wrap: assert property (p_full_only_wrap) else $error("full without wrap");

    property p_end_count_on;
        (capture && end_mode && full_r) |=> cnt_r != $past(cnt_r);
    endproperty
    a_end_count_on: assert property (p_end_count_on) else $error("end mode count stuck");

    property p_flag_clear_lines;
        !full_r |-> valid_lines == {1'b0, cnt_r};
    endproperty
    a_flag_clear_lines: assert property (p_flag_clear_lines) else $error("lines not count");

    property p_valid_range;
        valid_lines <= 7'h40;
    endproperty
    a_valid_range: assert property (p_valid_range) else $error("lines above 64");

    property p_sysrst_ctrl;
        !sys_rst_b |=> !session_armed && view == 2'b00;
    endproperty
    a_sysrst_ctrl: assert property (p_sysrst_ctrl) else $error("control kept in reset");

    // Trace buffer and readout
    property p_buf_write;
        capture |=> buf_r[$past(cnt_r)] == $past(trace_data);
    endproperty
    a_buf_write: assert property (p_buf_write) else $error("line stored wrong");

    property p_rptr_step;
        (rd_take && hit_tdata && !arm_wr) |=> rptr_r == 6'($past(rptr_r) + 6'h01);
    endproperty
    a_rptr_step: assert property (p_rptr_step) else $error("read pointer step wrong");

    property p_rptr_arm;
        arm_wr |=> rptr_r == 6'h00;
    endproperty
    a_rptr_arm: assert property (p_rptr_arm) else $error("read pointer not zeroed");

    property p_tdata_read;
        (avs_read && !ack_r && hit_tdata) |=> avs_readdata == {12'h000, $past(tline_r)};
    endproperty
    a_tdata_read: assert property (p_tdata_read) else $error("trace line read wrong");

    // Bus answers and read data
    property p_wait_once;
        (req && avs_waitrequest) |=> !req || !avs_waitrequest;
    endproperty
    a_wait_once: assert property (p_wait_once) else $error("second wait cycle");

    property p_wait_idle;
        !req |-> !avs_waitrequest;
    endproperty
    a_wait_idle: assert property (p_wait_idle) else $error("wait while idle");

    property p_readdata_hold;
        !(avs_read && !ack_r) |=> $stable(avs_readdata);
    endproperty
    a_readdata_hold: assert property (p_readdata_hold) else $error("read data moved");

    property p_count_field;
        (avs_read && !ack_r && hit_count) |=>
            avs_readdata == {24'h000000, $past(full_r), 1'b0, $past(cnt_r)};
    endproperty
    a_count_field: assert property (p_count_field) else $error("count read wrong");

    property p_status_field;
        (avs_read && !ack_r && hit_status) |=>
            avs_readdata == {24'h000000, $past(full_r), 6'h00, $past(arm)};
    endproperty
    a_status_field: assert property (p_status_field) else $error("status read wrong");

    property p_unmapped_zero;
        (avs_read && !ack_r && !(hit_ctrl || hit_status || hit_seq || hit_count || hit_tdata)) |=>
            avs_readdata == 32'h00000000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped not zero");

    // Shared address and per-state registers
    property p_ctrl_view;
        (wr_take && hit_ctrl && sys_rst_b) |=> view == $past(avs_writedata[1:0]);
    endproperty
    a_ctrl_view: assert property (p_ctrl_view) else $error("view select not written");

    property p_seq_write;
        (wr_take && seq_view && sys_rst_b) |=>
            seq_state_ctrl[$past(view)*8 +: 8] == $past(avs_writedata[7:0]);
    endproperty
    a_seq_write: assert property (p_seq_write) else $error("state register not written");

    property p_seq_view_read;
        (avs_read && !ack_r && seq_view) |=>
            avs_readdata == {24'h000000, $past(seq_state_ctrl[view*8 +: 8])};
    endproperty
    a_seq_view_read: assert property (p_seq_view_read) else $error("state view read wrong");

    property p_seq_hold;
        (sys_rst_b && !(wr_take && seq_view)) |=> $stable(seq_state_ctrl);
    endproperty
    a_seq_hold: assert property (p_seq_hold) else $error("state register moved");

    property p_match_nowrite;
        (wr_take && hit_seq && view == DTC_VIEW_MATCH && sys_rst_b) |=> $stable(seq_state_ctrl);
    endproperty
    a_match_nowrite: assert property (p_match_nowrite) else $error("match view wrote state");

endmodule

// >>> dtc_trace_counter_tb_top.sv
`timescale 1ns/1ps
module dtc_trace_counter_tb_top;
    import dtc_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic sys_rst_b = 1'b1;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic start = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0;
    logic [6:0] n = 7'h00;
    logic [31:0] avs_readdata, v;
    logic avs_waitrequest, trace_valid, session_armed;
    logic [19:0] trace_data;
    logic [7:0] match_flags;
    logic [23:0] seq_state_ctrl;
    logic [6:0] valid_lines;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    dtc_trace_counter DUT (.clk(clk), .rst_b(rst_b), .sys_rst_b(sys_rst_b),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trace_valid(trace_valid),
        .trace_data(trace_data), .match_flags(match_flags),
        .seq_state_ctrl(seq_state_ctrl), .session_armed(session_armed),
        .valid_lines(valid_lines));
    dtc_trace_src src (.clk(clk), .n(n), .start(start), .trace_valid(trace_valid),
        .trace_data(trace_data), .match_flags(match_flags));

    // Clock and hang guard
    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (failures == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bus accesses hold the request until waitrequest is seen low
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic burst(input logic [6:0] k);
        n <= k;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (k + 2) @(posedge clk);
    endtask

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(ADDR_COUNT, v);
        chk(v, 32'h00);
        wr(ADDR_CTRL, 8'hC0);
        burst(7'h05);
        chk({25'h0, valid_lines}, 32'h05);
        rd(ADDR_COUNT, v);
        chk(v, 32'h05);
        rd(ADDR_TDATA, v);
        chk(v, 32'h05);
        rd(ADDR_COUNT, v);
        chk(v, 32'h05);
        burst(7'h3B);
        rd(ADDR_COUNT, v);
        chk(v, 32'h80);
        chk({25'h0, valid_lines}, 32'h40);
        rd(ADDR_STATUS, v);
        chk(v, 32'h81);
        burst(7'h02);
        rd(ADDR_COUNT, v);
        chk(v, 32'h82);
        chk({25'h0, valid_lines}, 32'h40);
        sys_rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        sys_rst_b <= 1'b1;
        @(posedge clk);
        rd(ADDR_COUNT, v);
        chk(v, 32'h82);
        wr(ADDR_CTRL, 8'h80);
        rd(ADDR_STATUS, v);
        chk(v, 32'h01);
        rd(ADDR_COUNT, v);
        chk(v, 32'h00);
        burst(7'h40);
        rd(ADDR_COUNT, v);
        chk(v, 32'h80);
        chk({31'h0, session_armed}, 32'h0);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        rd(ADDR_COUNT, v);
        chk(v, 32'h00);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, 8'(i));
            wr(ADDR_SEQ, 8'(17 * (i + 1)));
        end
        chk({8'h00, seq_state_ctrl}, 32'h332211);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_CTRL, 8'(i));
            rd(ADDR_SEQ, v);
            chk(v, 32'(17 * (i + 1)));
        end
        wr(ADDR_CTRL, {6'h00, DTC_VIEW_MATCH});
        wr(ADDR_SEQ, 8'hFF);
        rd(ADDR_SEQ, v);
        chk(v, 32'hA5);
        chk({8'h00, seq_state_ctrl}, 32'h332211);
        rd(8'hFC, v);
        chk(v, 32'h0);
        wrap_up();
    end
endmodule

// >>> dtc_trace_src.sv
`timescale 1ns/1ps
// Processor-side trace source: one line a cycle for a burst of n lines
module dtc_trace_src #(
    parameter logic [7:0] MATCH = 8'hA5
) (
    input wire logic clk,
    input wire logic [6:0] n,
    input wire logic start,
    output logic trace_valid,
    output logic [19:0] trace_data,
    output logic [7:0] match_flags
);
    logic [6:0] left_r = 7'h00;
    // Burst counter, loaded by start
    always_ff @(posedge clk) begin
        if (start) begin
            left_r <= n;
        end else if (left_r != 7'h00) begin
            left_r <= left_r - 7'h01;
        end
    end
    // Idle data is inverted so a stale line never looks valid
    assign trace_valid = (left_r != 7'h00);
    assign trace_data = trace_valid ? {13'h0000, left_r} : ~{13'h0000, left_r};
    assign match_flags = MATCH;
endmodule
